// *** core/iolm_map.svh ***
// Purpose: register offsets, reset values and field widths of the I/O line mux block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: every register bit n acts on I/O line n only
`ifndef IOLM_MAP_SVH
`define IOLM_MAP_SVH

`define IOLM_LINES 32
`define IOLM_AW 8

`define IOLM_OFF_OUTPUT_DATA_LATCH 8'h00
`define IOLM_OFF_PERIPH_A_SELECT 8'h04
`define IOLM_OFF_PERIPH_B_SELECT 8'h08
`define IOLM_OFF_PERIPH_ASSIGN_STATUS 8'h0C
`define IOLM_OFF_OUTPUT_WRITE_UNMASK 8'h10
`define IOLM_OFF_OUTPUT_WRITE_MASK 8'h14
`define IOLM_OFF_OUTPUT_WRITE_MASK_STATUS 8'h18
`define IOLM_OFF_LINE_PIO_OWN 8'h1C

`define IOLM_RST_OUTPUT_DATA_LATCH 32'h0000_0000
`define IOLM_RST_PERIPH_ASSIGN_STATUS 32'h0000_0000
`define IOLM_RST_OUTPUT_WRITE_MASK_STATUS 32'h0000_0000
`define IOLM_RST_LINE_PIO_OWN 32'hFFFF_FFFF
`define IOLM_RDATA_ZERO 32'h0000_0000

`endif

// *** core/iolm_pkg.sv ***
// Purpose: shared types of the I/O line mux block
// Assumes: 32 I/O lines
// Notes: constants live in iolm_map.svh
package iolm_pkg;

  // one drive bundle: level and output enable per line
  typedef struct packed
  {
    logic [31:0] level;
    logic [31:0] enable;
  } iolm_drive_t;

  // apb request as seen by the slave
  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } iolm_apb_req_t;

endpackage

// *** core/iolm_line_cell.sv ***
// Purpose: steering of one I/O line between the PIO latch and peripherals A and B
// Assumes: all inputs synchronous to the block clock
// Notes: purely combinational; the selects come from flip-flops in the parent
`timescale 1ns/10ps
module iolm_line_cell
(
  input wire logic pio_own,
  input wire logic sel_b,
  input wire logic latch_level,
  input wire logic a_level,
  input wire logic a_enable,
  input wire logic b_level,
  input wire logic b_enable,
  input wire logic pad_in,
  output logic pad_level,
  output logic pad_enable,
  output logic a_in,
  output logic b_in
);

  always_comb
  begin
    if (pio_own)
    begin
      // latch one means high, zero means low
      pad_level = latch_level;
      pad_enable = 1'b1;
    end
    else if (sel_b)
    begin
      pad_level = b_level;
      pad_enable = b_enable;
    end
    else
    begin
      pad_level = a_level;
      pad_enable = a_enable;
    end
  end

  // a peripheral only sees the pad while the line is its own
  assign a_in = pad_in & ~pio_own & ~sel_b;
  assign b_in = pad_in & ~pio_own & sel_b;

endmodule

// *** core/iolm_top.sv ***
// Purpose: APB slave and per-line control for a 32-line I/O port with A/B peripheral mux
// Assumes: REF_CLK 25 MHz, RST_N synchronous active low, zero-wait APB
// Notes: read data is captured in the setup cycle, so every transfer ends in two cycles
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`include "iolm_map.svh"
`timescale 1ns/10ps
module iolm_top
(
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire iolm_pkg::iolm_drive_t PERA_DRV,
  input wire iolm_pkg::iolm_drive_t PERB_DRV,
  output logic [31:0] PERA_IN,
  output logic [31:0] PERB_IN,
  input wire logic [31:0] LINE_IN,
  output iolm_pkg::iolm_drive_t LINE_DRV
);

  iolm_pkg::iolm_apb_req_t req;
  logic setup_phase;
  logic wr_fire;
  logic hit_odl;
  logic hit_asel;
  logic hit_bsel;
  logic hit_absr;
  logic hit_ower;
  logic hit_owdr;
  logic hit_owsr;
  logic hit_own;
  logic addr_mapped;
  logic [31:0] odl;
  logic [31:0] absr;
  logic [31:0] owsr;
  logic [31:0] pio_own;
  logic [31:0] next_odl;
  logic [31:0] next_rdata;
  logic next_slverr;

  assign req.psel = PSEL;
  assign req.penable = PENABLE;
  assign req.pwrite = PWRITE;
  assign req.paddr = PADDR;
  assign req.pwdata = PWDATA;

  // address decode
  assign hit_odl = (req.paddr == `IOLM_OFF_OUTPUT_DATA_LATCH);
  assign hit_asel = (req.paddr == `IOLM_OFF_PERIPH_A_SELECT);
  assign hit_bsel = (req.paddr == `IOLM_OFF_PERIPH_B_SELECT);
  assign hit_absr = (req.paddr == `IOLM_OFF_PERIPH_ASSIGN_STATUS);
  assign hit_ower = (req.paddr == `IOLM_OFF_OUTPUT_WRITE_UNMASK);
  assign hit_owdr = (req.paddr == `IOLM_OFF_OUTPUT_WRITE_MASK);
  assign hit_owsr = (req.paddr == `IOLM_OFF_OUTPUT_WRITE_MASK_STATUS);
  assign hit_own = (req.paddr == `IOLM_OFF_LINE_PIO_OWN);
  assign addr_mapped = hit_odl | hit_asel | hit_bsel | hit_absr | hit_ower | hit_owdr
                       | hit_owsr | hit_own;

  assign setup_phase = req.psel & ~req.penable;
  // no wait states: the access phase always completes
  assign PREADY = 1'b1;
  assign wr_fire = req.psel & req.penable & req.pwrite & PREADY;

  // peripheral assignment: set bits pick A or B, zero bits leave the line alone
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      absr <= `IOLM_RST_PERIPH_ASSIGN_STATUS;
    end
    else if (wr_fire && hit_asel)
    begin
      absr <= absr & ~req.pwdata;
    end
    else if (wr_fire && hit_bsel)
    begin
      absr <= absr | req.pwdata;
    end
  end

  // output write mask: one means latch writes reach the line
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      owsr <= `IOLM_RST_OUTPUT_WRITE_MASK_STATUS;
    end
    else if (wr_fire && hit_ower)
    begin
      owsr <= owsr | req.pwdata;
    end
    else if (wr_fire && hit_owdr)
    begin
      owsr <= owsr & ~req.pwdata;
    end
  end

  // masked bits keep their old value, so a full-word write cannot disturb them
  always_comb
  begin
    next_odl = (req.pwdata & owsr) | (odl & ~owsr);
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      odl <= `IOLM_RST_OUTPUT_DATA_LATCH;
    end
    else if (wr_fire && hit_odl)
    begin
      odl <= next_odl;
    end
  end

  // line ownership: one hands the line to the data latch, zero to a peripheral
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      pio_own <= `IOLM_RST_LINE_PIO_OWN;
    end
    else if (wr_fire && hit_own)
    begin
      pio_own <= req.pwdata;
    end
  end

  // read mux; write-only registers read as zero
  always_comb
  begin
    next_rdata = `IOLM_RDATA_ZERO;
    next_slverr = 1'b0;
    if (hit_odl)
    begin
      next_rdata = odl;
    end
    else if (hit_absr)
    begin
      next_rdata = absr;
    end
    else if (hit_owsr)
    begin
      next_rdata = owsr;
    end
    else if (hit_own)
    begin
      next_rdata = pio_own;
    end
    if (!addr_mapped)
    begin
      next_slverr = 1'b1;
    end
  end

  // captured at the setup edge, held through the access phase
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      PRDATA <= `IOLM_RDATA_ZERO;
      PSLVERR <= 1'b0;
    end
    else if (setup_phase)
    begin
      PRDATA <= req.pwrite ? `IOLM_RDATA_ZERO : next_rdata;
      PSLVERR <= next_slverr;
    end
  end

  // one steering cell per line, bit n wired only to line n
  genvar gi;
  generate
    for (gi = 0; gi < `IOLM_LINES; gi = gi + 1)
    begin : g_line
      iolm_line_cell u_cell
      (
        .pio_own(pio_own[gi]),
        .sel_b(absr[gi]),
        .latch_level(odl[gi]),
        .a_level(PERA_DRV.level[gi]),
        .a_enable(PERA_DRV.enable[gi]),
        .b_level(PERB_DRV.level[gi]),
        .b_enable(PERB_DRV.enable[gi]),
        .pad_in(LINE_IN[gi]),
        .pad_level(LINE_DRV.level[gi]),
        .pad_enable(LINE_DRV.enable[gi]),
        .a_in(PERA_IN[gi]),
        .b_in(PERB_IN[gi])
      );
    end
  endgenerate

  // assertions

  a_asel_clears_bits: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_asel) |=> ((absr & $past(req.pwdata)) == 32'h0000_0000))
    else $error("a select write left a line on peripheral B");

  a_bsel_sets_bits: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_bsel) |=> ((absr & $past(req.pwdata)) == $past(req.pwdata)))
    else $error("b select write did not move a line to peripheral B");

  a_absr_read_view: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (setup_phase && !req.pwrite && hit_absr) |=> (PRDATA == $past(absr)))
    else $error("assignment status read does not match the line choice");

  a_ower_sets_mask: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_ower) |=> ((owsr & $past(req.pwdata)) == $past(req.pwdata)))
    else $error("unmask write did not open the line");

  a_owdr_clears_mask: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_owdr) |=> ((owsr & $past(req.pwdata)) == 32'h0000_0000))
    else $error("mask write did not close the line");

  a_owsr_read_view: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (setup_phase && !req.pwrite && hit_owsr) ##1 (req.psel && req.penable)
    |-> (PRDATA == $past(owsr, 1)))
    else $error("write mask status read is wrong");

  a_other_bits_hold: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && (hit_asel || hit_bsel))
    |=> ((absr & ~$past(req.pwdata)) == ($past(absr) & ~$past(req.pwdata))))
    else $error("a select write touched a line whose bit was zero");

  a_masked_latch_write: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_odl)
    |=> ((odl & ~$past(owsr)) == ($past(odl) & ~$past(owsr)))
        && ((odl & $past(owsr)) == ($past(req.pwdata) & $past(owsr))))
    else $error("output data write ignored the write mask");

  a_line_level_follows: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    ((LINE_DRV.level & pio_own) == (odl & pio_own))
    && ((LINE_DRV.enable & pio_own) == pio_own))
    else $error("pio owned line does not follow the data latch");

  a_line_to_periph: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    ((LINE_DRV.level & ~pio_own & ~absr) == (PERA_DRV.level & ~pio_own & ~absr))
    && ((LINE_DRV.level & ~pio_own & absr) == (PERB_DRV.level & ~pio_own & absr)))
    else $error("peripheral line driven by the wrong function");

  a_mask_stable_idle: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    !(wr_fire && (hit_ower || hit_owdr)) |=> $stable(owsr))
    else $error("write mask changed without a mask write");

  // register bus view of the data latch, of the write-only words and of refused transfers
  a_sel_reads_zero: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (setup_phase && !req.pwrite && (hit_asel || hit_bsel))
    |=> (PRDATA == 32'h0000_0000))
    else $error("a peripheral select word read back non-zero");

  a_mask_reads_zero: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (setup_phase && !req.pwrite && (hit_ower || hit_owdr))
    |=> (PRDATA == 32'h0000_0000))
    else $error("a write mask command word read back non-zero");

  a_odl_read_view: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (setup_phase && !req.pwrite && hit_odl) |=> (PRDATA == $past(odl)))
    else $error("output data read does not match the latch");

  a_unmapped_errors: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (setup_phase && !addr_mapped) |=> (PSLVERR && (PRDATA == 32'h0000_0000)))
    else $error("unmapped word did not answer with an error");

  // state changes only through its own command words
  a_absr_only_select: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    !(wr_fire && (hit_asel || hit_bsel)) |=> $stable(absr))
    else $error("assignment status changed without a select write");

  a_absr_write_ignored: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_absr) |=> $stable(absr))
    else $error("a write to the assignment status changed it");

  a_owsr_write_ignored: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_owsr) |=> $stable(owsr))
    else $error("a write to the write mask status changed it");

  a_unmask_other_bits: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_ower)
    |=> ((owsr & ~$past(req.pwdata)) == ($past(owsr) & ~$past(req.pwdata))))
    else $error("unmask write touched a line whose bit was zero");

  a_mask_other_bits: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_owdr)
    |=> ((owsr & ~$past(req.pwdata)) == ($past(owsr) & ~$past(req.pwdata))))
    else $error("mask write touched a line whose bit was zero");

  a_latch_only_write: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    !(wr_fire && hit_odl) |=> $stable(odl))
    else $error("output data latch changed without a latch write");

  a_masked_line_holds: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_odl)
    |=> ((LINE_DRV.level & pio_own & ~$past(owsr)) == ($past(odl) & pio_own & ~$past(owsr))))
    else $error("a masked line moved on an output data write");

  a_unmask_line_follows: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (wr_fire && hit_odl)
    |=> ((LINE_DRV.level & pio_own & $past(owsr)) == ($past(req.pwdata) & pio_own & $past(owsr))))
    else $error("an unmasked line did not take the written level");

  // pad routing to and from the peripherals
  a_pera_gated_in: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    PERA_IN == (LINE_IN & ~pio_own & ~absr))
    else $error("peripheral A input does not follow its own lines");

  a_perb_gated_in: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    PERB_IN == (LINE_IN & ~pio_own & absr))
    else $error("peripheral B input does not follow its own lines");

  a_pera_enable_route: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (LINE_DRV.enable & ~pio_own & ~absr) == (PERA_DRV.enable & ~pio_own & ~absr))
    else $error("line enable does not follow peripheral A");

  a_perb_enable_route: assert property (
    @(posedge REF_CLK) disable iff (!RST_N)
    (LINE_DRV.enable & ~pio_own & absr) == (PERB_DRV.enable & ~pio_own & absr))
    else $error("line enable does not follow peripheral B");

endmodule

// *** sim/iolm_periph_model.sv ***
// Purpose: stand-in for peripherals A and B driving their pad requests
// Assumes: both peripherals run on the block clock
// Notes: drives change every cycle so a stale mux select shows up at once
`timescale 1ns/10ps
module iolm_periph_model
(
  input wire logic clk,
  output iolm_pkg::iolm_drive_t a_drv,
  output iolm_pkg::iolm_drive_t b_drv
);
  logic [31:0] lfsr = 32'h1B3D_5F79;
  always @(posedge clk)
  begin
    lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
  end
  // b is never a copy of a, so a swapped owner cannot pass
  assign a_drv = {lfsr, {lfsr[15:0], lfsr[31:16]}};
  assign b_drv = {~lfsr, lfsr ^ {lfsr[7:0], lfsr[31:8]}};
endmodule

// *** sim/io_line_mux_and_write_mask_bench.sv ***
// Purpose: self-checking bench of the I/O line mux block
// Assumes: zero-wait APB slave, registers at the offsets of iolm_map.svh
// Notes: random writes over every offset, unmapped ones included
`include "iolm_map.svh"
`timescale 1ns/10ps
module io_line_mux_and_write_mask_bench;
  logic REF_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0000_0000;
  logic [31:0] LINE_IN = 32'h0000_0000;
  logic [31:0] PRDATA, PERA_IN, PERB_IN;
  logic PREADY, PSLVERR;
  iolm_pkg::iolm_drive_t pa, pb, LINE_DRV;
  logic [31:0] lat, ab, ows, own, q, d;
  logic e;
  logic [7:0] a;
  int seed, n_fail, checks;
  initial
  begin
    forever #20 REF_CLK = ~REF_CLK;
  end
  iolm_periph_model u_iolm_periph_model (.clk(REF_CLK), .a_drv(pa), .b_drv(pb));
  iolm_top u_iolm_top (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PERA_DRV(pa), .PERB_DRV(pb), .PERA_IN(PERA_IN), .PERB_IN(PERB_IN),
    .LINE_IN(LINE_IN), .LINE_DRV(LINE_DRV));
  task wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int i;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    i = 0;
    do
    begin
      @(posedge REF_CLK);
      i++;
    end
    while (PREADY !== 1'b1 && i < 50);
    if (PREADY !== 1'b1)
    begin
      n_fail++;
      wrap_up();
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // one idle edge, so the next call never reassigns the strobes in this step
    @(posedge REF_CLK);
  endtask
  function automatic logic [31:0] exp_rd(input logic [7:0] ad);
    case (ad)
      `IOLM_OFF_OUTPUT_DATA_LATCH: return lat;
      `IOLM_OFF_PERIPH_ASSIGN_STATUS: return ab;
      `IOLM_OFF_OUTPUT_WRITE_MASK_STATUS: return ows;
      `IOLM_OFF_LINE_PIO_OWN: return own;
      default: return 32'h0000_0000;
    endcase
  endfunction
  // write-only registers read back as zero
  task check_all;
    #1;
    chk("line_level", LINE_DRV.level, (own & lat) | (~own & ~ab & pa.level)
      | (~own & ab & pb.level));
    chk("line_enable", LINE_DRV.enable, own | (~own & ~ab & pa.enable)
      | (~own & ab & pb.enable));
    chk("per_a_in", PERA_IN, LINE_IN & ~own & ~ab);
    chk("per_b_in", PERB_IN, LINE_IN & ~own & ab);
    @(posedge REF_CLK);
    for (int r = 0; r < 10; r++)
    begin
      apb(1'b0, 8'(r * 4), 32'h0000_0000);
      chk("read", {e, q}, {r > 7, exp_rd(8'(r * 4))});
    end
  endtask
  initial
  begin
    seed = 34595;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    {lat, ab, ows, own} = {`IOLM_RST_OUTPUT_DATA_LATCH, `IOLM_RST_PERIPH_ASSIGN_STATUS,
      `IOLM_RST_OUTPUT_WRITE_MASK_STATUS, `IOLM_RST_LINE_PIO_OWN};
    @(posedge REF_CLK);
    check_all();
    $display("reset test done");
    for (int k = 0; k < 80; k++)
    begin
      // the early ownership write hands every line to the peripherals; the other early writes set the boundary bits
      a = (k < 10) ? 8'(k * 4) : 8'(({$random(seed)} % 10) * 4);
      d = (k < 10) ? ((k == 7) ? 32'h0000_0000 : 32'h8000_0001 | $random(seed)) : $random(seed);
      LINE_IN <= $random(seed);
      apb(1'b1, a, d);
      case (a)
        `IOLM_OFF_OUTPUT_DATA_LATCH: lat = (lat & ~ows) | (d & ows);
        `IOLM_OFF_PERIPH_A_SELECT: ab = ab & ~d;
        `IOLM_OFF_PERIPH_B_SELECT: ab = ab | d;
        `IOLM_OFF_OUTPUT_WRITE_UNMASK: ows = ows | d;
        `IOLM_OFF_OUTPUT_WRITE_MASK: ows = ows & ~d;
        `IOLM_OFF_LINE_PIO_OWN: own = d;
        default: ;
      endcase
      chk("write_err", e, a > 8'h1C);
      check_all();
    end
    $display("random register test done");
    wrap_up();
  end
endmodule
